//--- verilog/ict_pkg.sv
`default_nettype none
package ict_pkg;
	// cycle figures at zero wait states
	localparam logic [4:0] CYC_ONE = 5'h01;
	localparam logic [4:0] CYC_TWO = 5'h02;
	localparam logic [4:0] CYC_THREE = 5'h03;
	localparam logic [4:0] CYC_POP_RET = 5'h03;
	localparam logic [4:0] CYC_SHIFT_ALL = 5'h00;
	// wide-encoding fields
	localparam logic [15:0] ENC_BARRIER_HI = 16'hF3BF;
	localparam logic [7:0] ENC_BARRIER_LO = 8'h8F;
	localparam logic [3:0] BAR_DATA_SYNC = 4'h4;
	localparam logic [3:0] BAR_DATA_MEM = 4'h5;
	localparam logic [3:0] BAR_INSTR_SYNC = 4'h6;
	localparam logic [11:0] ENC_SRREAD_HI = 12'hF3E;
	localparam logic [11:0] ENC_SRWRITE_HI = 12'hF38;
	// hint selectors
	localparam logic [3:0] HINT_WAIT_EVENT = 4'h2;
	localparam logic [3:0] HINT_WAIT_IRQ = 4'h3;
	// shift amount that clears or sign-fills a word
	localparam logic [7:0] SHIFT_FULL = 8'h20;
	// reset values
	localparam logic RST_READY = 1'b1;

	typedef enum logic [2:0] {
		CLS_DATA = 3'h0,
		CLS_MEM = 3'h1,
		CLS_MULTI = 3'h2,
		CLS_BRANCH = 3'h3,
		CLS_HINT = 3'h4,
		CLS_SYS = 3'h5,
		CLS_TRAP = 3'h6,
		CLS_UNDEF = 3'h7
	} ict_class_type;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} ict_fsm_type;

	typedef struct packed {
		ict_fsm_type state;
		logic ready;
		logic done;
		logic undef;
		logic wide;
		logic stallable;
		logic [4:0] remain;
		logic [4:0] cycles;
		ict_class_type cls;
		logic [31:0] result;
	} ict_state_type;
endpackage
`default_nettype wire

//--- verilog/ict_popcount.sv
`timescale 1ns/100ps
`default_nettype none
module ict_popcount #(
	parameter int WIDTH = 8,
	parameter int CW = 4
) (
	input wire logic [WIDTH-1:0] bits,
	output logic [CW-1:0] count
);
	if (WIDTH < 1 || WIDTH >= (1 << CW)) begin : g_chk
		$error("popcount width does not fit its count");
	end

	always_comb begin
		count = '0;
		for (int i = 0; i < WIDTH; i++) begin
			count = count + CW'(bits[i]);
		end
	end
endmodule
`default_nettype wire

//--- verilog/ict_decoder.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - all narrow encodings except branch-on-zero forms, if-then
// - wide encodings: call, barriers, special register moves
// - figures assume no wait; stalls lengthen
// - simple data operations finish in one cycle
// - arithmetic right shift: one cycle, keeps sign
// - rotate right by register: one cycle
// - address from stack or program counter: one
// - single load or store: two or one
// - bus target two cycles, I/O port one
// - multiple transfers take one plus register count, three plus for pop with program counter
// - count includes link register or program counter
// - register branches and unconditional branch: two cycles
// - conditional branch: two taken, one not
// - byte and halfword extension: one cycle
// - byte reversals: one cycle
// - wait hint figures exclude suspended time
module ict_decoder import ict_pkg::*; #(
	parameter int TRAP_CYCLES = 1
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// instruction request
	input wire logic INSTR_VALID,
	input wire logic [15:0] INSTR_HI,
	input wire logic [15:0] INSTR_LO,
	input wire logic BRANCH_TAKEN,
	input wire logic TARGET_IO,
	input wire logic STALL,
	// operands
	input wire logic [31:0] OPERAND_A,
	input wire logic [31:0] OPERAND_B,
	// completion
	output logic INSTR_READY,
	output logic DONE,
	output logic [4:0] CYCLES,
	output logic [2:0] CLASS,
	output logic UNDEFINED,
	output logic WIDE,
	output logic [31:0] RESULT
);
	if (TRAP_CYCLES < 1 || TRAP_CYCLES > 31) begin : g_chk
		$error("trap cycle count out of range");
	end

	localparam logic [4:0] TRAP_CYC = 5'(TRAP_CYCLES);

	ict_state_type cur_reg;
	ict_state_type cur_next;
	ict_class_type dec_cls;
	logic [4:0] dec_cyc;
	logic dec_undef;
	logic dec_wide;
	logic dec_stall;
	logic dec_asr;
	logic [3:0] list_cnt;
	logic [4:0] list_n;
	logic [7:0] amt;
	logic [1:0] sh_op;
	logic sh_en;
	logic [31:0] dp_result;
	logic accept;

	ict_popcount #(.WIDTH(8), .CW(4)) u_count (
		.bits(INSTR_HI[7:0]),
		.count(list_cnt)
	);

	assign accept = INSTR_VALID && cur_reg.ready;
	assign list_n = {1'b0, list_cnt} + {4'h0, INSTR_HI[8]};

	// decode class and cycle figure
	always_comb begin
		dec_cls = CLS_DATA;
		dec_cyc = CYC_ONE;
		dec_undef = 1'b0;
		dec_wide = 1'b0;
		dec_stall = 1'b0;
		if (INSTR_HI[15:11] == 5'b11101 || INSTR_HI[15:12] == 4'hF) begin
			dec_wide = 1'b1;
			dec_cls = CLS_SYS;
			dec_cyc = CYC_THREE;
			if (INSTR_HI[15:11] == 5'b11110 && INSTR_LO[15:14] == 2'b11 && INSTR_LO[12]) begin
				dec_cls = CLS_BRANCH;
			end else if (INSTR_HI == ENC_BARRIER_HI && INSTR_LO[15:8] == ENC_BARRIER_LO &&
					(INSTR_LO[7:4] == BAR_DATA_SYNC || INSTR_LO[7:4] == BAR_DATA_MEM ||
					INSTR_LO[7:4] == BAR_INSTR_SYNC)) begin
				dec_cls = CLS_SYS;
			end else if ((INSTR_HI[15:4] == ENC_SRREAD_HI || INSTR_HI[15:4] == ENC_SRWRITE_HI) &&
					INSTR_LO[15:14] == 2'b10 && !INSTR_LO[12]) begin
				dec_cls = CLS_SYS;
			end else begin
				dec_undef = 1'b1;
			end
		end else begin
			priority casez (INSTR_HI[15:11])
				5'b00???: dec_cls = CLS_DATA;
				5'b01000: begin
					if (INSTR_HI[10] && INSTR_HI[9:8] == 2'b11) begin
						dec_cls = CLS_BRANCH;
						dec_cyc = CYC_TWO;
					end else if (INSTR_HI[10] && INSTR_HI[9:8] != 2'b01 &&
							{INSTR_HI[7], INSTR_HI[2:0]} == 4'hF) begin
						dec_cls = CLS_BRANCH;
						dec_cyc = CYC_TWO;
					end
				end
				5'b01001, 5'b0101?, 5'b011??, 5'b100??: begin
					dec_cls = CLS_MEM;
					dec_cyc = TARGET_IO ? CYC_ONE : CYC_TWO;
					dec_stall = !TARGET_IO;
				end
				5'b1010?: dec_cls = CLS_DATA;
				5'b1011?: begin
					priority casez (INSTR_HI[11:8])
						4'b0000, 4'b0010: dec_cls = CLS_DATA;
						4'b?0?1: dec_undef = 1'b1;
						4'b010?: begin
							dec_cls = CLS_MULTI;
							dec_cyc = CYC_ONE + list_n;
							dec_stall = 1'b1;
						end
						4'b110?: begin
							dec_cls = CLS_MULTI;
							dec_cyc = (INSTR_HI[8] ? CYC_POP_RET : CYC_ONE) + list_n;
							dec_stall = 1'b1;
						end
						4'b0110: dec_undef = (INSTR_HI[7:5] != 3'b011);
						4'b1010: dec_undef = (INSTR_HI[7:6] == 2'b10);
						4'b1110: begin
							dec_cls = CLS_TRAP;
							dec_cyc = TRAP_CYC;
						end
						4'b1111: begin
							if (INSTR_HI[3:0] != 4'h0) begin
								dec_undef = 1'b1;
							end else begin
								dec_cls = CLS_HINT;
								if (INSTR_HI[7:4] == HINT_WAIT_EVENT || INSTR_HI[7:4] == HINT_WAIT_IRQ) begin
									dec_cyc = CYC_TWO;
									dec_stall = 1'b1;
								end
							end
						end
						default: dec_undef = 1'b1;
					endcase
				end
				5'b1100?: begin
					dec_cls = CLS_MULTI;
					dec_cyc = CYC_ONE + {1'b0, list_cnt};
					dec_stall = 1'b1;
				end
				5'b1101?: begin
					if (INSTR_HI[11:8] == 4'hE) begin
						dec_undef = 1'b1;
					end else if (INSTR_HI[11:8] == 4'hF) begin
						dec_cls = CLS_TRAP;
						dec_cyc = TRAP_CYC;
					end else begin
						dec_cls = CLS_BRANCH;
						dec_cyc = BRANCH_TAKEN ? CYC_TWO : CYC_ONE;
					end
				end
				5'b11100: begin
					dec_cls = CLS_BRANCH;
					dec_cyc = CYC_TWO;
				end
				default: dec_undef = 1'b1;
			endcase
		end
		if (dec_undef) begin
			dec_cls = CLS_UNDEF;
			dec_cyc = CYC_ONE;
			dec_stall = 1'b0;
		end
	end

	// shift, rotate, extend and reverse datapath
	always_comb begin
		amt = OPERAND_B[7:0];
		sh_op = 2'h0;
		sh_en = 1'b0;
		dec_asr = 1'b0;
		dp_result = 32'h0000_0000;
		if (INSTR_HI[15:13] == 3'b000 && INSTR_HI[12:11] != 2'b11) begin
			sh_en = 1'b1;
			sh_op = INSTR_HI[12:11];
			amt = {3'h0, INSTR_HI[10:6]};
			if (amt == 8'h00 && sh_op != 2'h0) begin
				amt = SHIFT_FULL;
			end
		end else if (INSTR_HI[15:10] == 6'b010000) begin
			sh_en = 1'b1;
			unique case (INSTR_HI[9:6])
				4'h2: sh_op = 2'h0;
				4'h3: sh_op = 2'h1;
				4'h4: sh_op = 2'h2;
				4'h7: sh_op = 2'h3;
				default: sh_en = 1'b0;
			endcase
		end
		if (sh_en) begin
			unique case (sh_op)
				2'h0: dp_result = (amt >= SHIFT_FULL) ? 32'h0000_0000 : OPERAND_A << amt[4:0];
				2'h1: dp_result = (amt >= SHIFT_FULL) ? 32'h0000_0000 : OPERAND_A >> amt[4:0];
				2'h2: begin
					dec_asr = 1'b1;
					dp_result = (amt >= SHIFT_FULL) ? {32{OPERAND_A[31]}} :
						32'($signed(OPERAND_A) >>> amt[4:0]);
				end
				2'h3: dp_result = (OPERAND_A >> amt[4:0]) |
					(OPERAND_A << (6'h20 - {1'b0, amt[4:0]}));
			endcase
		end else if (INSTR_HI[15:8] == 8'hB2) begin
			unique case (INSTR_HI[7:6])
				2'h0: dp_result = {{16{OPERAND_A[15]}}, OPERAND_A[15:0]};
				2'h1: dp_result = {{24{OPERAND_A[7]}}, OPERAND_A[7:0]};
				2'h2: dp_result = {16'h0000, OPERAND_A[15:0]};
				2'h3: dp_result = {24'h00_0000, OPERAND_A[7:0]};
			endcase
		end else if (INSTR_HI[15:8] == 8'hBA) begin
			unique case (INSTR_HI[7:6])
				2'h0: dp_result = {OPERAND_A[7:0], OPERAND_A[15:8], OPERAND_A[23:16], OPERAND_A[31:24]};
				2'h1: dp_result = {OPERAND_A[23:16], OPERAND_A[31:24], OPERAND_A[7:0], OPERAND_A[15:8]};
				2'h3: dp_result = {{16{OPERAND_A[7]}}, OPERAND_A[7:0], OPERAND_A[15:8]};
				default: dp_result = 32'h0000_0000;
			endcase
		end
	end

	// sequencer
	always_comb begin
		cur_next = cur_reg;
		cur_next.done = 1'b0;
		unique case (cur_reg.state)
			ST_IDLE: begin
				if (accept) begin
					cur_next.cls = dec_cls;
					cur_next.undef = dec_undef;
					cur_next.wide = dec_wide;
					cur_next.cycles = dec_cyc;
					cur_next.stallable = dec_stall;
					cur_next.result = dec_undef ? 32'h0000_0000 : dp_result;
					if (dec_cyc == CYC_ONE) begin
						cur_next.done = 1'b1;
					end else begin
						cur_next.state = ST_BUSY;
						cur_next.ready = 1'b0;
						cur_next.remain = dec_cyc - CYC_TWO;
					end
				end
			end
			ST_BUSY: begin
				if (!(STALL && cur_reg.stallable)) begin
					if (cur_reg.remain == CYC_SHIFT_ALL) begin
						cur_next.state = ST_IDLE;
						cur_next.ready = 1'b1;
						cur_next.done = 1'b1;
					end else begin
						cur_next.remain = cur_reg.remain - CYC_ONE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cur_reg <= '{state: ST_IDLE, ready: RST_READY, cls: CLS_DATA, default: '0};
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign INSTR_READY = cur_reg.ready;
	assign DONE = cur_reg.done;
	assign CYCLES = cur_reg.cycles;
	assign CLASS = cur_reg.cls;
	assign UNDEFINED = cur_reg.undef;
	assign WIDE = cur_reg.wide;
	assign RESULT = cur_reg.result;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);

	AST_DATA_ONE: assert property (accept && INSTR_HI[15:14] == 2'b00 |=> DONE && CYCLES == 5'h01)
		else $error("simple data op not one cycle");
	AST_ASR_SIGN: assert property (accept && dec_asr && OPERAND_A[31] |=> DONE && RESULT[31])
		else $error("arithmetic shift lost sign");
	AST_MEM_IO: assert property (accept && dec_cls == CLS_MEM && TARGET_IO |=> DONE && CYCLES == 5'h01)
		else $error("io access not one cycle");
	AST_MEM_BUS: assert property (accept && dec_cls == CLS_MEM && !TARGET_IO && !STALL ##1 !STALL |-> !DONE ##1 DONE)
		else $error("bus access not two cycles");
	AST_BCOND: assert property (accept && INSTR_HI[15:12] == 4'hD && INSTR_HI[11:9] != 3'h7 |=>
		CYCLES == ($past(BRANCH_TAKEN) ? 5'h02 : 5'h01))
		else $error("conditional branch cycles wrong");
	AST_ZERO_BRANCH_UNDEF: assert property (accept && INSTR_HI[15:12] == 4'hB && !INSTR_HI[10] && INSTR_HI[8] |=>
		DONE && UNDEFINED && RESULT == 32'h0000_0000)
		else $error("branch-on-zero form not undefined");
	AST_MULTI: assert property (accept && INSTR_HI[15:12] == 4'hC |=>
		CYCLES == 5'($countones($past(INSTR_HI[7:0])) + 1))
		else $error("multiple transfer count wrong");
	AST_CALL_THREE: assert property (accept && INSTR_HI[15:11] == 5'b11110 && INSTR_LO[15:14] == 2'b11 && INSTR_LO[12]
		|=> !DONE && !INSTR_READY ##1 !DONE ##1 DONE && INSTR_READY && WIDE)
		else $error("wide call not three cycles");
endmodule
`default_nettype wire

//--- bench/ict_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ict_mem_model (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// request seen at the core
	input wire logic valid,
	input wire logic ready,
	input wire logic [4:0] waits,
	// wait states towards the core
	output logic stall
);
	logic [4:0] cnt_reg;
	// wait states start right after the accept edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 5'h00;
		end else if (valid && ready) begin
			cnt_reg <= waits;
		end else if (cnt_reg != 5'h00) begin
			cnt_reg <= cnt_reg - 5'h01;
		end
	end
	assign stall = cnt_reg != 5'h00;
endmodule
`default_nettype wire

//--- bench/test_instruction_cycle_timing.sv
`timescale 1ns/100ps
`default_nettype none
module test_instruction_cycle_timing;
	import ict_pkg::*;
	logic ref_clk, arst_n, instr_valid, branch_taken, target_io, stall;
	logic [15:0] instr_hi, instr_lo;
	logic [31:0] operand_a, operand_b, result;
	logic instr_ready, done, undefined, wide;
	logic [4:0] cycles, waits;
	logic [2:0] cls_out;
	int failures = 0;
	int tests_run = 0;
	int seed;

	ict_decoder #(.TRAP_CYCLES(4)) ict_decoder_inst (.REF_CLK(ref_clk), .ARST_N(arst_n),
		.INSTR_VALID(instr_valid), .INSTR_HI(instr_hi), .INSTR_LO(instr_lo),
		.BRANCH_TAKEN(branch_taken), .TARGET_IO(target_io), .STALL(stall),
		.OPERAND_A(operand_a), .OPERAND_B(operand_b), .INSTR_READY(instr_ready),
		.DONE(done), .CYCLES(cycles), .CLASS(cls_out), .UNDEFINED(undefined),
		.WIDE(wide), .RESULT(result));
	ict_mem_model ict_mem_model_inst (.clk(ref_clk), .arst_n(arst_n), .valid(instr_valid),
		.ready(instr_ready), .waits(waits), .stall(stall));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// reference datapath result for one instruction
	function automatic logic [31:0] eres(input logic [15:0] h, input logic [31:0] a, input logic [31:0] b);
		int s;
		logic signed [31:0] sa, sr, s2;
		s = int'(b[7:0]);
		sa = a;
		sr = sa >>> ((s > 31) ? 31 : s);
		s2 = sa >>> 2;
		case (h)
			16'h0108: return a << 4;
			16'h0808: return 32'h00000000;
			16'h1088: return s2;
			16'h4088: return a << s;
			16'h40C8: return a >> s;
			16'h4108: return sr;
			16'h41C8: return (a >> (s % 32)) | (a << (32 - (s % 32)));
			16'hB208: return {{16{a[15]}}, a[15:0]};
			16'hB248: return {{24{a[7]}}, a[7:0]};
			16'hB288: return {16'h0000, a[15:0]};
			16'hB2C8: return {24'h000000, a[7:0]};
			16'hBA08: return {a[7:0], a[15:8], a[23:16], a[31:24]};
			16'hBA48: return {a[23:16], a[31:24], a[7:0], a[15:8]};
			16'hBAC8: return {{16{a[7]}}, a[7:0], a[15:8]};
			default: return 32'h00000000;
		endcase
	endfunction

	// one instruction: accept, count edges to completion, compare
	task automatic t(input logic [15:0] h, input int c, input int k, input logic [15:0] l = 16'h0000,
		input logic tk = 1'b0, input logic io = 1'b0, input int w = 0);
		int n;
		int lat;
		logic [31:0] a, b;
		a = $urandom;
		b = 32'($urandom % 40);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_hi <= h;
		instr_lo <= l;
		branch_taken <= tk;
		target_io <= io;
		operand_a <= a;
		operand_b <= b;
		waits <= 5'(w);
		#1;
		while (instr_ready !== 1'b1) begin
			@(posedge ref_clk);
			#1;
		end
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		n = 1;
		#1;
		while (done !== 1'b1 && n < 40) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		lat = c + ((k == 1 || k == 2 || (k == 4 && c == 2)) ? w : 0);
		chk(32'(n), 32'(lat));
		chk(32'(cycles), 32'(c));
		chk(32'(cls_out), 32'(k));
		chk(32'(wide), 32'(h[15:11] > 5'h1C));
		chk(32'(undefined), 32'(k == 7));
		chk(result, eres(h, a, b));
		chk(32'(instr_ready), 32'h00000001);
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		print_verdict();
	end

	initial begin
		arst_n = 1'b0;
		instr_valid = 1'b0;
		instr_hi = 16'h0000;
		instr_lo = 16'h0000;
		branch_taken = 1'b0;
		target_io = 1'b0;
		operand_a = 32'h00000000;
		operand_b = 32'h00000000;
		waits = 5'h00;
		seed = $urandom(79268);
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		#1;
		chk({instr_ready, done, undefined, wide, cycles, cls_out}, 32'h00000800);
		t(16'h0108, 1, 0);
		t(16'h0808, 1, 0);
		t(16'h1088, 1, 0);
		for (int r = 0; r < 3; r++) begin
			t(16'h4088 + 16'(r * 64), 1, 0);
		end
		t(16'h41C8, 1, 0);
		t(16'h4687, 2, 3);
		t(16'hB672, 1, 0);
		t(16'h1840, 1, 0);
		t(16'h4348, 1, 0);
		t(16'hA800, 1, 0);
		t(16'hA000, 1, 0);
		for (int r = 0; r < 4; r++) begin
			t(16'hB208 + 16'(r * 64), 1, 0);
		end
		t(16'hBA08, 1, 0);
		t(16'hBA48, 1, 0);
		t(16'hBAC8, 1, 0);
		$display("data tests finished");
		t(16'h6808, 2, 1);
		t(16'h6808, 1, 1, , , 1'b1);
		t(16'h6008, 2, 1, , , , 3);
		t(16'hC803, 3, 2);
		t(16'hB4FF, 9, 2, , , , 2);
		t(16'hB501, 3, 2);
		t(16'hBD01, 5, 2);
		$display("memory tests finished");
		t(16'hD001, 2, 3, , 1'b1);
		t(16'hD001, 1, 3);
		t(16'hE000, 2, 3, , , , 3);
		t(16'h4708, 2, 3);
		t(16'h4788, 2, 3);
		t(16'hF000, 3, 3, 16'hF800);
		$display("branch tests finished");
		t(16'hBF20, 2, 4, , , , 3);
		t(16'hBF30, 2, 4);
		t(16'hBF10, 1, 4);
		t(16'hBF40, 1, 4);
		t(16'hBE00, 4, 6);
		t(16'hF3BF, 3, 5, 16'h8F5F);
		t(16'hF3BF, 3, 5, 16'h8F4F);
		t(16'hF3BF, 3, 5, 16'h8F6F);
		t(16'hF3EF, 3, 5, 16'h8000);
		t(16'hF380, 3, 5, 16'h8800);
		t(16'hDF00, 4, 6);
		$display("system tests finished");
		t(16'hB100, 1, 7);
		t(16'hB900, 1, 7);
		t(16'hBF08, 1, 7);
		t(16'hDE00, 1, 7);
		t(16'hBA88, 1, 7);
		t(16'hE800, 1, 7, 16'h0000);
		$display("undefined tests finished");
		print_verdict();
	end
endmodule
`default_nettype wire
